// ===== rca_arbiter.sv
/*
 * Radio coexistence arbiter: apb register slave, pad routing of the three
 * coexistence signals, medium arbitration between the local radio and a
 * companion radio.
 * Assumes one 100 MHz clock, a synchronous active-low reset, pads that are
 * asynchronous to clk, and local radio status inputs on clk.
 */
// Our own choices: the register addresses and the APB interface to the registers.
// Contract
// - three coexistence signals are routed to software-selected pads
// - activity output asserted while local radio is active per traffic select
// - companion activity asserted makes us stop occupying the medium
// - priority input is optional; when unused it is ignored
// - priority plus companion activity aborts a transmission in progress
// - one enable switches the whole coexistence function on or off
// - polarity setting selects active-high or active-low signals
// - manual force mode lets software set the activity output directly
// - a setting chooses whether priority takes part in arbitration
// - traffic select picks transmit, receive or both for activity output
`include "rca_consts.svh"
module rca_arbiter #(
   parameter int NUM_PADS = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [`RCA_ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [NUM_PADS-1:0] pad_in,
   output logic [NUM_PADS-1:0] pad_out,
   output logic [NUM_PADS-1:0] pad_oe,
   input wire logic wlan_tx_active,
   input wire logic wlan_rx_active,
   input wire logic wlan_tx_busy,
   output logic wlan_rf_grant,
   output logic wlan_tx_abort,
   output logic wlan_activity_out
);

   // registers
   logic [31:0] ctrl_ff, nxt_ctrl;
   logic [31:0] padsel_ff, nxt_padsel;
   logic [31:0] prdata_ff, nxt_prdata;
   logic pready_ff, nxt_pready;
   logic pslverr_ff, nxt_pslverr;
   rca_pkg::rca_arb_t state_ff, nxt_state;
   logic grant_ff, nxt_grant;
   logic abort_ff, nxt_abort;
   logic act_out_ff, nxt_act_out;
   logic [NUM_PADS-1:0] pad_out_ff, nxt_pad_out;
   logic [NUM_PADS-1:0] pad_oe_ff, nxt_pad_oe;

   // decoded configuration and conditioned inputs
   logic [NUM_PADS-1:0] pad_sync;
   logic cfg_en, cfg_pol, cfg_force, cfg_fval, cfg_pri;
   logic [1:0] cfg_trf;
   logic [`RCA_SEL_W-1:0] sel_out, sel_in1, sel_in2;
   logic comp_act, comp_pri, local_act;
   logic apb_access, apb_commit;
   logic addr_ok;

   // picks one pad by index; an index beyond the pads reads low
   function automatic logic pad_pick(
      input logic [NUM_PADS-1:0] v,
      input logic [`RCA_SEL_W-1:0] idx
   );
      logic r;
      r = 1'b0;
      for (int i = 0; i < NUM_PADS; i++) begin
         if (idx == i[`RCA_SEL_W-1:0]) begin
            r = v[i];
         end
      end
      return r;
   endfunction : pad_pick

   // turns a pad level into an active level and back
   function automatic logic pol_map(input logic lvl, input logic low_act);
      return lvl ^ low_act;
   endfunction : pol_map

   // pads are asynchronous to clk, so every pad is filtered first
   rca_sync #(
      .W(NUM_PADS)
   ) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d(pad_in),
      .q(pad_sync)
   );

   // configuration fields
   assign cfg_en = ctrl_ff[`RCA_CTRL_EN];
   assign cfg_pol = ctrl_ff[`RCA_CTRL_POL];
   assign cfg_force = ctrl_ff[`RCA_CTRL_FORCE];
   assign cfg_fval = ctrl_ff[`RCA_CTRL_FVAL];
   assign cfg_pri = ctrl_ff[`RCA_CTRL_PRI];
   assign cfg_trf = ctrl_ff[`RCA_CTRL_TRF_HI:`RCA_CTRL_TRF_LO];
   assign sel_out = padsel_ff[`RCA_SEL_OUT_HI:`RCA_SEL_OUT_LO];
   assign sel_in1 = padsel_ff[`RCA_SEL_IN1_HI:`RCA_SEL_IN1_LO];
   assign sel_in2 = padsel_ff[`RCA_SEL_IN2_HI:`RCA_SEL_IN2_LO];

   // companion signals from their selected pads, in active terms
   always_comb begin
      comp_act = pol_map(pad_pick(pad_sync, sel_in1), cfg_pol);
      // an unused priority pad is masked out entirely
      comp_pri = cfg_pri
         & pol_map(pad_pick(pad_sync, sel_in2), cfg_pol);
   end

   // local activity by traffic class, or software value in force mode
   always_comb begin
      local_act = (cfg_trf[`RCA_TRF_TX] & wlan_tx_active)
         | (cfg_trf[`RCA_TRF_RX] & wlan_rx_active);
      if (cfg_force) begin
         local_act = cfg_fval;
      end
   end

   // arbitration of the medium
   always_comb begin
      nxt_state = state_ff;
      nxt_abort = 1'b0;
      if (!cfg_en) begin
         // companion inputs do not count while switched off
         nxt_state = rca_pkg::RCA_OWN;
      end else begin
         unique case (state_ff)
            rca_pkg::RCA_OWN: begin
               if (comp_act) begin
                  if (wlan_tx_busy && comp_pri) begin
                     nxt_state = rca_pkg::RCA_YIELD;
                     nxt_abort = 1'b1;
                  end else if (wlan_tx_busy) begin
                     // without priority a frame on air may finish
                     nxt_state = rca_pkg::RCA_DRAIN;
                  end else begin
                     nxt_state = rca_pkg::RCA_YIELD;
                  end
               end
            end
            rca_pkg::RCA_DRAIN: begin
               if (!comp_act) begin
                  nxt_state = rca_pkg::RCA_OWN;
               end else if (comp_pri && wlan_tx_busy) begin
                  // priority arriving mid-frame still pre-empts it;
                  // a frame that has just ended needs no abort
                  nxt_state = rca_pkg::RCA_YIELD;
                  nxt_abort = 1'b1;
               end else if (!wlan_tx_busy) begin
                  nxt_state = rca_pkg::RCA_YIELD;
               end
            end
            rca_pkg::RCA_YIELD: begin
               if (!comp_act) begin
                  nxt_state = rca_pkg::RCA_OWN;
               end
            end
         endcase
      end
      // no new access is started once the companion has been seen
      nxt_grant = (nxt_state == rca_pkg::RCA_OWN);
   end

   // activity output level and its pad
   always_comb begin
      // disabled means inactive level, which is high for active-low
      nxt_act_out = cfg_en & local_act;
      nxt_pad_out = '0;
      nxt_pad_oe = '0;
      for (int i = 0; i < NUM_PADS; i++) begin
         if (sel_out == i[`RCA_SEL_W-1:0]) begin
            nxt_pad_out[i] = pol_map(nxt_act_out, cfg_pol);
            nxt_pad_oe[i] = 1'b1;
         end
      end
   end

   // arbitration and pad registers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_ff <= rca_pkg::RCA_OWN;
         grant_ff <= 1'b1;
         abort_ff <= 1'b0;
         act_out_ff <= 1'b0;
         pad_out_ff <= '0;
         pad_oe_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         grant_ff <= nxt_grant;
         abort_ff <= nxt_abort;
         act_out_ff <= nxt_act_out;
         pad_out_ff <= nxt_pad_out;
         pad_oe_ff <= nxt_pad_oe;
      end
   end

   // apb: one wait state, write lands on the edge that sees pready
   assign apb_access = psel & penable & ~pready_ff;
   assign apb_commit = psel & penable & pready_ff & pwrite;

   // address decode; status is read only
   always_comb begin
      unique case (paddr)
         `RCA_OFF_CTRL: addr_ok = 1'b1;
         `RCA_OFF_PADSEL: addr_ok = 1'b1;
         `RCA_OFF_STATUS: addr_ok = ~pwrite;
         default: addr_ok = 1'b0;
      endcase
   end

   // bus answer and register writes
   always_comb begin
      nxt_pready = apb_access;
      nxt_pslverr = apb_access & ~addr_ok;
      nxt_prdata = '0;
      nxt_ctrl = ctrl_ff;
      nxt_padsel = padsel_ff;
      if (apb_access && !pwrite) begin
         unique case (paddr)
            `RCA_OFF_CTRL: nxt_prdata = ctrl_ff;
            `RCA_OFF_PADSEL: nxt_prdata = padsel_ff;
            `RCA_OFF_STATUS: begin
               nxt_prdata[`RCA_ST_ACT] = comp_act;
               nxt_prdata[`RCA_ST_PRI] = comp_pri;
               nxt_prdata[`RCA_ST_OUT] = act_out_ff;
               nxt_prdata[`RCA_ST_GRANT] = grant_ff;
               nxt_prdata[`RCA_ST_ABORT] = abort_ff;
               nxt_prdata[`RCA_ST_ST_HI:`RCA_ST_ST_LO] = state_ff;
            end
            default: nxt_prdata = '0;
         endcase
      end
      // an erroring write changes nothing
      if (apb_commit && !pslverr_ff) begin
         if (paddr == `RCA_OFF_CTRL) begin
            nxt_ctrl = pwdata & `RCA_CTRL_MASK;
         end
         if (paddr == `RCA_OFF_PADSEL) begin
            nxt_padsel = pwdata & `RCA_PADSEL_MASK;
         end
      end
   end

   // bus and configuration registers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl_ff <= `RCA_CTRL_RST;
         padsel_ff <= `RCA_PADSEL_RST;
         prdata_ff <= '0;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         ctrl_ff <= nxt_ctrl;
         padsel_ff <= nxt_padsel;
         prdata_ff <= nxt_prdata;
         pready_ff <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
      end
   end

   // all outputs straight from flops
   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign pad_out = pad_out_ff;
   assign pad_oe = pad_oe_ff;
   assign wlan_rf_grant = grant_ff;
   assign wlan_tx_abort = abort_ff;
   assign wlan_activity_out = act_out_ff;

endmodule : rca_arbiter

// ===== rca_checker.sv
/*
 * Port assertions for the coexistence arbiter.
 * Assumes the companion activity input stays routed to pad 1.
 */
`include "rca_consts.svh"
module rca_checker #(
   parameter int NUM_PADS = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [`RCA_ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [NUM_PADS-1:0] pad_in,
   input wire logic [NUM_PADS-1:0] pad_out,
   input wire logic [NUM_PADS-1:0] pad_oe,
   input wire logic wlan_tx_active,
   input wire logic wlan_rx_active,
   input wire logic wlan_tx_busy,
   input wire logic wlan_rf_grant,
   input wire logic wlan_tx_abort,
   input wire logic wlan_activity_out
);
   logic [31:0] ctrl_ff;
   logic [31:0] nxt_ctrl;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // shadow control word, taken at the completing apb edge
   always_comb begin
      nxt_ctrl = ctrl_ff;
      if (psel && penable && pready && pwrite && paddr == `RCA_OFF_CTRL)
         nxt_ctrl = pwdata & `RCA_CTRL_MASK;
      if (!rst_n)
         nxt_ctrl = `RCA_CTRL_RST;
   end
   always_ff @(posedge clk) begin
      ctrl_ff <= nxt_ctrl;
   end
   // six samples cover three sync flops, the filter and the grant flop
   sequence s_comp_on;
      (ctrl_ff[0] && (pad_in[1] ^ ctrl_ff[1]) && !wlan_tx_busy) [*6];
   endsequence
   a_ready_wait: assert property (
      $rose(penable) && psel |-> !pready ##1 pready)
      else $error("pready not after one wait state");
   a_ready_pulse: assert property (
      pready |-> psel && penable ##1 !pready)
      else $error("pready outside access or too long");
   a_err_refuse: assert property (
      pready && (paddr > `RCA_OFF_STATUS ||
      (pwrite && paddr == `RCA_OFF_STATUS)) |-> pslverr)
      else $error("refused access without pslverr");
   a_oe_single: assert property (
      $past(rst_n) |-> $onehot(pad_oe))
      else $error("pad enable not on exactly one pad");
   a_pad_mirror: assert property (
      pad_out == (pad_oe & {NUM_PADS{wlan_activity_out ^ $past(ctrl_ff[1])}}))
      else $error("activity pad level wrong");
   a_act_select: assert property (
      $past(ctrl_ff[0]) && !$past(ctrl_ff[2]) |-> wlan_activity_out ==
      (($past(wlan_tx_active) && $past(ctrl_ff[5])) ||
      ($past(wlan_rx_active) && $past(ctrl_ff[6]))))
      else $error("activity not per traffic select");
   a_force_val: assert property (
      $past(ctrl_ff[0]) && $past(ctrl_ff[2]) |->
      wlan_activity_out == $past(ctrl_ff[3]))
      else $error("forced activity wrong");
   a_off_quiet: assert property (
      !$past(ctrl_ff[0]) |-> wlan_rf_grant && !wlan_activity_out &&
      !wlan_tx_abort)
      else $error("disabled block not quiet");
   a_abort_cause: assert property (
      wlan_tx_abort |-> !wlan_rf_grant && $past(ctrl_ff[4]) &&
      $past(wlan_tx_busy))
      else $error("abort without cause");
   a_comp_yield: assert property (
      s_comp_on |-> !wlan_rf_grant)
      else $error("medium kept while companion active");
endmodule : rca_checker

bind rca_arbiter rca_checker #(.NUM_PADS(NUM_PADS)) u_chk (.clk(clk),
   .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
   .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
   .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
   .wlan_tx_active(wlan_tx_active), .wlan_rx_active(wlan_rx_active),
   .wlan_tx_busy(wlan_tx_busy), .wlan_rf_grant(wlan_rf_grant),
   .wlan_tx_abort(wlan_tx_abort), .wlan_activity_out(wlan_activity_out));

// ===== rca_companion.sv
/*
 * Behavioural companion radio on the pads: activity on pad 1,
 * priority on pad 2, watches the activity pad of the local radio.
 * Assumes the bench sets pol to match the programmed polarity.
 */
module rca_companion (
   input wire logic clk,
   input wire logic pol,
   input wire logic want,
   input wire logic urgent,
   input wire logic wlan_pad,
   output logic [15:0] pad_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic act;
   logic [15:0] noise = 16'h0000;
   // unrelated pads wander so a wrong index never reads steady
   always @(posedge clk) noise <= {noise[14:0], ~noise[15]};
   // defer to local traffic unless urgent traffic claims precedence
   assign act = want && (urgent || !(wlan_pad ^ pol));
   assign pad_in = {noise[15:3], (want && urgent) ^ pol, act ^ pol,
      noise[0]};
endmodule : rca_companion

// ===== rca_consts.svh
/*
 * Constants for the radio coexistence arbiter: register offsets, field
 * positions, reset values and traffic selection codes.
 * Assumes it is included by bare name; holds definitions only.
 */
`ifndef RCA_CONSTS_SVH
`define RCA_CONSTS_SVH

// apb address width and register byte offsets
`define RCA_ADDR_W 12
`define RCA_OFF_CTRL 12'h000
`define RCA_OFF_PADSEL 12'h004
`define RCA_OFF_STATUS 12'h008

// control register fields
`define RCA_CTRL_EN 0
`define RCA_CTRL_POL 1
`define RCA_CTRL_FORCE 2
`define RCA_CTRL_FVAL 3
`define RCA_CTRL_PRI 4
`define RCA_CTRL_TRF_LO 5
`define RCA_CTRL_TRF_HI 6
`define RCA_CTRL_MASK 32'h0000_007F
`define RCA_CTRL_RST 32'h0000_0060

// traffic selection codes
`define RCA_TRF_TX 0
`define RCA_TRF_RX 1

// pad select register fields
`define RCA_SEL_W 4
`define RCA_SEL_OUT_LO 0
`define RCA_SEL_OUT_HI 3
`define RCA_SEL_IN1_LO 8
`define RCA_SEL_IN1_HI 11
`define RCA_SEL_IN2_LO 16
`define RCA_SEL_IN2_HI 19
`define RCA_PADSEL_MASK 32'h000F_0F0F
`define RCA_PADSEL_RST 32'h0002_0100

// status register fields
`define RCA_ST_ACT 0
`define RCA_ST_PRI 1
`define RCA_ST_OUT 2
`define RCA_ST_GRANT 3
`define RCA_ST_ABORT 4
`define RCA_ST_ST_LO 5
`define RCA_ST_ST_HI 6

`endif

// ===== rca_pkg.sv
/*
 * Types shared by the radio coexistence arbiter.
 * Assumes nothing of its surroundings.
 */
package rca_pkg;

   // who holds the shared medium
   typedef enum logic [1:0] {
      RCA_OWN,
      RCA_DRAIN,
      RCA_YIELD
   } rca_arb_t;

endpackage : rca_pkg

// ===== rca_sync.sv
/*
 * Three-flop synchroniser with an agreement filter for a bus of pad inputs.
 * Assumes inputs are asynchronous to clk; output is on clk.
 */
module rca_sync #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] s1_ff, s2_ff, s3_ff, q_ff;
   logic [W-1:0] nxt_q;

   // a bit only moves once the second and third flops agree
   always_comb begin
      nxt_q = q_ff;
      for (int i = 0; i < W; i++) begin
         if (s2_ff[i] == s3_ff[i]) begin
            nxt_q[i] = s3_ff[i];
         end
      end
   end

   // first stage feeds only the second one
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
         q_ff <= '0;
      end else begin
         s1_ff <= d;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         q_ff <= nxt_q;
      end
   end

   assign q = q_ff;

endmodule : rca_sync

// ===== testbench.sv
/*
 * Self-checking bench for the coexistence arbiter over apb.
 * Assumes the design and companion model are compiled before it.
 */
`include "rca_consts.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, psel, penable, pwrite, tx, rx, busy, want, urgent;
   logic pol, pready, pslverr, err, grant, abort, act, seen;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] pad_in, pad_out, pad_oe;
   int err_total, comparisons;
   rca_arbiter #(.NUM_PADS(16)) uut (.clk(clk), .rst_n(rst_n),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out),
      .pad_oe(pad_oe), .wlan_tx_active(tx), .wlan_rx_active(rx),
      .wlan_tx_busy(busy), .wlan_rf_grant(grant), .wlan_tx_abort(abort),
      .wlan_activity_out(act));
   rca_companion peer (.clk(clk), .pol(pol), .want(want),
      .urgent(urgent), .wlan_pad(pad_out[0]), .pad_in(pad_in));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task print_verdict;
      $display("errors %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : print_verdict
   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // one apb transfer, then an idle cycle; waits are bounded
   task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
      if (n >= 16) begin
         err_total++;
         $display("wrong value at %0t: no pready", $time);
         print_verdict();
      end
   endtask : bus
   task tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   // wait for the grant level, noting any abort pulse on the way
   task wait_grant(input logic v);
      int n;
      n = 0;
      seen = 1'b0;
      while (grant !== v && n < 32) begin
         @(posedge clk);
         n++;
         if (abort === 1'b1)
            seen = 1'b1;
      end
      chk(grant, v);
      if (grant !== v)
         print_verdict();
   endtask : wait_grant
   initial begin
      err_total = 0;
      comparisons = 0;
      {rst_n, psel, penable, pwrite, tx, rx, busy, want, urgent} = 9'h000;
      {pol, paddr, pwdata} = 45'h0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      // defaults, refused places and masked bits
      bus(1'b0, `RCA_OFF_CTRL, 32'h0); chk(rd, 32'h0000_0060);
      bus(1'b0, `RCA_OFF_PADSEL, 32'h0); chk(rd, 32'h0002_0100);
      chk(pad_oe, 16'h0001);
      bus(1'b1, 12'h00C, 32'hFFFF_FFFF); chk(err, 1'b1);
      bus(1'b1, `RCA_OFF_STATUS, 32'h0); chk(err, 1'b1);
      bus(1'b1, `RCA_OFF_CTRL, 32'hFFFF_FF80);
      bus(1'b0, `RCA_OFF_CTRL, 32'h0); chk(rd, 32'h0);
      // every traffic code, transmit then receive
      for (int t = 0; t < 4; t++) begin
         bus(1'b1, `RCA_OFF_CTRL, {25'h0, t[1:0], 5'h01});
         tx <= 1'b1;
         tick(2); chk(act, t[0]);
         tx <= 1'b0;
         rx <= 1'b1;
         tick(2); chk(act, t[1]);
         rx <= 1'b0;
      end
      // active-low pads invert the level
      pol <= 1'b1;
      bus(1'b1, `RCA_OFF_CTRL, 32'h0000_0023);
      tx <= 1'b1;
      tick(2); chk(pad_out, 16'h0000);
      tx <= 1'b0;
      tick(2); chk(pad_out, 16'h0001);
      // force sets activity high and low; tx is raised only while no traffic class is selected
      pol <= 1'b0;
      bus(1'b1, `RCA_OFF_CTRL, 32'h0000_000D);
      tick(2); chk(act, 1'b1);
      tx <= 1'b1;
      bus(1'b1, `RCA_OFF_CTRL, 32'h0000_0005);
      tick(2); chk(act, 1'b0);
      tx <= 1'b0;
      bus(1'b1, `RCA_OFF_PADSEL, 32'h0002_0105);
      tick(2); chk(pad_oe, 16'h0020);
      bus(1'b1, `RCA_OFF_PADSEL, 32'h0002_0100);
      // companion takes the medium and hands it back
      bus(1'b1, `RCA_OFF_CTRL, 32'h0000_0061);
      want <= 1'b1;
      wait_grant(1'b0);
      want <= 1'b0;
      wait_grant(1'b1);
      // priority unused: no abort, no new access, the frame drains
      {busy, want, urgent} <= 3'b111;
      wait_grant(1'b0); chk(seen, 1'b0);
      tick(2); chk(grant, 1'b0);
      bus(1'b0, `RCA_OFF_STATUS, 32'h0); chk(rd, 32'h0000_0021);
      busy <= 1'b0;
      tick(2);
      bus(1'b0, `RCA_OFF_STATUS, 32'h0); chk(rd, 32'h0000_0041);
      {want, urgent} <= 2'b00;
      wait_grant(1'b1);
      // priority used: the frame on air is aborted
      bus(1'b1, `RCA_OFF_CTRL, 32'h0000_0071);
      {busy, want, urgent} <= 3'b111;
      wait_grant(1'b0); chk(seen, 1'b1);
      {busy, want, urgent} <= 3'b000;
      wait_grant(1'b1);
      // disabled: companion ignored, activity quiet
      bus(1'b1, `RCA_OFF_CTRL, 32'h0000_0060);
      want <= 1'b1;
      tx <= 1'b1;
      tick(8); chk({grant, act}, 2'b10);
      print_verdict();
   end
endmodule : testbench
